// File: tsp_pkg.sv
// Constants shared by the time source packet builder.
`default_nettype none
package tsp_pkg;
  // Header field values.
  localparam logic [2:0]  TSP_VERSION     = 3'h0;
  localparam logic        TSP_TYPE        = 1'b0;
  localparam logic        TSP_DFH_FLAG    = 1'b0;
  localparam logic [10:0] TSP_APID        = 11'h000;
  localparam logic [1:0]  TSP_SEG_FLAGS   = 2'h3;
  localparam logic [15:0] TSP_LENGTH      = 16'h0007;
  // Widths.
  localparam int          TSP_SEQ_W       = 14;
  localparam int          TSP_COARSE_W    = 32;
  localparam int          TSP_FINE_W      = 16;
  localparam int          TSP_TIME_W      = 48;
  localparam int          TSP_RATE_W      = 4;
  localparam int          TSP_VC_W        = 3;
  localparam int          TSP_VCFC_W      = 8;
  localparam int          TSP_PKT_W       = 112;
  localparam int          TSP_CNT_W       = 16;
  // Octet counts.
  localparam logic [3:0]  TSP_PKT_OCTETS  = 4'hE;
  localparam logic [3:0]  TSP_LAST_OCTET  = 4'hD;
  // Data field values.
  localparam logic [3:0]  TSP_S_SPARE     = 4'h0;
  localparam logic [7:0]  TSP_P_FIELD     = 8'h2E;
  localparam logic        TSP_UNSYNC_MARK = 1'b1;
  // Frame that carries the time reference.
  localparam logic [2:0]  TSP_TIME_VC     = 3'h0;
  localparam logic [7:0]  TSP_TIME_VCFC   = 8'h00;
  // Reset values and the sequence count maximum.
  localparam logic [13:0] TSP_SEQ_RST     = 14'h0000;
  localparam logic [13:0] TSP_SEQ_MAX     = 14'h3FFF;
  localparam logic [47:0] TSP_TIME_RST    = 48'h0000_0000_0000;
  localparam logic [3:0]  TSP_IDX_RST     = 4'h0;
  localparam logic [15:0] TSP_CNT_RST     = 16'h0000;
endpackage : tsp_pkg
`default_nettype wire

// File: tsp_seq_counter.sv
// Fourteen-bit source sequence counter of the time packet.
`timescale 1ns/1ps
`default_nettype none
module tsp_seq_counter
  import tsp_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 inc_i,
  output logic      [TSP_SEQ_W-1:0] count_o
);

  logic [TSP_SEQ_W-1:0] count_ff;
  logic [TSP_SEQ_W-1:0] nxt_count;

  // Reset only ever returns the count to zero, never elsewhere.
  always_comb begin
    nxt_count = count_ff;
    if (inc_i) begin
      if (count_ff == TSP_SEQ_MAX) begin
        nxt_count = TSP_SEQ_RST;
      end else begin
        nxt_count = count_ff + 14'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_ff <= TSP_SEQ_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count_o = count_ff;

endmodule : tsp_seq_counter
`default_nettype wire

// File: tsp_time_latch.sv
// Captures elapsed time at the reference frame marker.
`timescale 1ns/1ps
`default_nettype none
module tsp_time_latch
  import tsp_pkg::*;
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    marker_i,
  input  wire logic [TSP_VC_W-1:0]     vc_id_i,
  input  wire logic [TSP_VCFC_W-1:0]   vc_fc_i,
  input  wire logic [TSP_COARSE_W-1:0] coarse_i,
  input  wire logic [TSP_FINE_W-1:0]   fine_i,
  input  wire logic                    synced_i,
  input  wire logic                    take_i,
  output logic      [TSP_TIME_W-1:0]   time_o,
  output logic                         avail_o,
  output logic                         hit_o
);

  logic [TSP_TIME_W-1:0] time_ff;
  logic [TSP_TIME_W-1:0] nxt_time;
  logic                  avail_ff;
  logic                  nxt_avail;
  logic                  hit;

  assign hit = marker_i && (vc_id_i == TSP_TIME_VC)
               && (vc_fc_i == TSP_TIME_VCFC);

  // A new sample in the same cycle as a take keeps the flag set.
  always_comb begin
    nxt_time  = time_ff;
    nxt_avail = avail_ff;
    if (take_i) begin
      nxt_avail = 1'b0;
    end
    if (hit) begin
      nxt_time  = {coarse_i, fine_i};
      if (!synced_i) begin
        nxt_time[TSP_TIME_W-1] = TSP_UNSYNC_MARK;
      end
      nxt_avail = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      time_ff  <= TSP_TIME_RST;
      avail_ff <= 1'b0;
    end else begin
      time_ff  <= nxt_time;
      avail_ff <= nxt_avail;
    end
  end

  assign time_o  = time_ff;
  assign avail_o = avail_ff;
  assign hit_o   = hit;

endmodule : tsp_time_latch
`default_nettype wire

// File: tsp_packet_builder.sv
// Time source packet builder: samples time and streams the packet.
//
// Overview of operation
// - Header is 48 bits in fixed field order.
// - Version field is always binary zero.
// - Type bit is always zero.
// - Data field header flag is always zero.
// - Application identifier is all zeros.
// - Segmentation flags are always one-one.
// - Sequence count rises by one per packet.
// - Counter only ever jumps back to zero.
// - Counter wraps from its maximum to zero.
// - Length field holds the constant seven.
// - First data octet: spare zeros, rate code.
// - Second data octet declares four-plus-two time.
// - Time bits 0 to 31 hold seconds.
// - Time bits 32 to 47 hold subseconds.
// - Sample at marker of frame zero, channel zero.
// - Time field is six octets, no preamble.
// - Unsynchronised time sets the field's top bit.
`timescale 1ns/1ps
`default_nettype none
module tsp_packet_builder
  import tsp_pkg::*;
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  // Elapsed time counter.
  input  wire logic [TSP_COARSE_W-1:0] coarse_time_i,
  input  wire logic [TSP_FINE_W-1:0]   fine_time_i,
  input  wire logic                    time_synced_i,
  // Frame generator marker report.
  input  wire logic                    marker_start_i,
  input  wire logic [TSP_VC_W-1:0]     marker_vc_i,
  input  wire logic [TSP_VCFC_W-1:0]   marker_vcfc_i,
  // Control.
  input  wire logic                    send_req_i,
  input  wire logic [TSP_RATE_W-1:0]   rate_code_i,
  input  wire logic                    clr_status_i,
  // Octet stream towards the frame generator.
  output logic      [7:0]              tx_data_o,
  output logic                         tx_valid_o,
  input  wire logic                    tx_ready_i,
  output logic                         tx_first_o,
  output logic                         tx_last_o,
  // Status.
  output logic                         busy_o,
  output logic                         sample_avail_o,
  output logic                         req_refused_o,
  output logic                         sample_lost_o,
  output logic                         pkt_done_o,
  output logic      [TSP_SEQ_W-1:0]    seq_count_o,
  output logic      [TSP_CNT_W-1:0]    pkt_count_o
);

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SEND
  } tsp_state_e;

  // Packs the header in transmission order, first bit at the top.
  function automatic logic [47:0] tsp_header(
    input logic [TSP_SEQ_W-1:0] seq
  );
    tsp_header = {TSP_VERSION,
                  TSP_TYPE,
                  TSP_DFH_FLAG,
                  TSP_APID,
                  TSP_SEG_FLAGS,
                  seq,
                  TSP_LENGTH};
  endfunction : tsp_header

  // Packs the eight octet data field.
  function automatic logic [63:0] tsp_data(
    input logic [TSP_RATE_W-1:0] rate,
    input logic [TSP_TIME_W-1:0] tfield
  );
    tsp_data = {TSP_S_SPARE,
                rate,
                TSP_P_FIELD,
                tfield};
  endfunction : tsp_data

  // Sub-block wiring.
  logic [TSP_SEQ_W-1:0]  seq_count;
  logic [TSP_TIME_W-1:0] sample_time;
  logic                  sample_avail;
  logic                  marker_hit;
  logic                  take_sample;
  logic                  release_pkt;

  // Packet state.
  tsp_state_e            state_ff;
  tsp_state_e            nxt_state;
  logic [TSP_PKT_W-1:0]  pkt_ff;
  logic [TSP_PKT_W-1:0]  nxt_pkt;
  logic [3:0]            idx_ff;
  logic [3:0]            nxt_idx;

  // Status state.
  logic                  refused_ff;
  logic                  nxt_refused;
  logic                  lost_ff;
  logic                  nxt_lost;
  logic                  done_ff;
  logic                  nxt_done;
  logic [TSP_CNT_W-1:0]  cnt_ff;
  logic [TSP_CNT_W-1:0]  nxt_cnt;

  logic                  accept;
  logic                  start;

  tsp_seq_counter u_seq (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .inc_i     (release_pkt),
    .count_o   (seq_count)
  );

  tsp_time_latch u_latch (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .marker_i  (marker_start_i),
    .vc_id_i   (marker_vc_i),
    .vc_fc_i   (marker_vcfc_i),
    .coarse_i  (coarse_time_i),
    .fine_i    (fine_time_i),
    .synced_i  (time_synced_i),
    .take_i    (take_sample),
    .time_o    (sample_time),
    .avail_o   (sample_avail),
    .hit_o     (marker_hit)
  );

  // A request is honoured only when idle and a sample is waiting.
  assign start       = (state_ff == ST_IDLE) && send_req_i
                       && sample_avail;
  assign take_sample = start;
  assign accept      = (state_ff == ST_SEND) && tx_ready_i;
  assign release_pkt = accept && (idx_ff == TSP_LAST_OCTET);

  // The whole packet is frozen at start so the stream never tears
  // if a new marker arrives mid-packet; the cost is 112 flops.
  always_comb begin
    nxt_state = state_ff;
    nxt_pkt   = pkt_ff;
    nxt_idx   = idx_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_pkt   = {tsp_header(seq_count),
                       tsp_data(rate_code_i, sample_time)};
          nxt_idx   = TSP_IDX_RST;
          nxt_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (accept) begin
          nxt_pkt = {pkt_ff[TSP_PKT_W-9:0], 8'h00};
          if (idx_ff == TSP_LAST_OCTET) begin
            nxt_idx   = TSP_IDX_RST;
            nxt_state = ST_IDLE;
          end else begin
            nxt_idx = idx_ff + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      pkt_ff   <= '0;
      idx_ff   <= TSP_IDX_RST;
    end else begin
      state_ff <= nxt_state;
      pkt_ff   <= nxt_pkt;
      idx_ff   <= nxt_idx;
    end
  end

  // Sticky refused and lost flags, one-cycle done pulse; a new event wins over a clear.
  always_comb begin
    nxt_refused = refused_ff;
    nxt_lost    = lost_ff;
    nxt_done    = release_pkt;
    nxt_cnt     = cnt_ff;
    if (clr_status_i) begin
      nxt_refused = 1'b0;
      nxt_lost    = 1'b0;
    end
    if (send_req_i && !start) begin
      nxt_refused = 1'b1;
    end
    if (marker_hit && sample_avail && !take_sample) begin
      nxt_lost = 1'b1;
    end
    if (release_pkt) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      refused_ff <= 1'b0;
      lost_ff    <= 1'b0;
      done_ff    <= 1'b0;
      cnt_ff     <= TSP_CNT_RST;
    end else begin
      refused_ff <= nxt_refused;
      lost_ff    <= nxt_lost;
      done_ff    <= nxt_done;
      cnt_ff     <= nxt_cnt;
    end
  end

  assign tx_data_o      = pkt_ff[TSP_PKT_W-1 -: 8];
  assign tx_valid_o     = (state_ff == ST_SEND);
  assign tx_first_o     = tx_valid_o && (idx_ff == TSP_IDX_RST);
  assign tx_last_o      = tx_valid_o && (idx_ff == TSP_LAST_OCTET);
  assign busy_o         = (state_ff == ST_SEND);
  assign sample_avail_o = sample_avail;
  assign req_refused_o  = refused_ff;
  assign sample_lost_o  = lost_ff;
  assign pkt_done_o     = done_ff;
  assign seq_count_o    = seq_count;
  assign pkt_count_o    = cnt_ff;

endmodule : tsp_packet_builder
`default_nettype wire

// File: tsp_pkt_checker.sv
// Concurrent checks on the ports of the time packet builder.
`timescale 1ns/1ps
`default_nettype none
module tsp_pkt_checker
  import tsp_pkg::*;
(
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  input wire logic                  marker_start_i,
  input wire logic [TSP_VC_W-1:0]   marker_vc_i,
  input wire logic [TSP_VCFC_W-1:0] marker_vcfc_i,
  input wire logic                  send_req_i,
  input wire logic [7:0]            tx_data_o,
  input wire logic                  tx_valid_o,
  input wire logic                  tx_ready_i,
  input wire logic                  tx_first_o,
  input wire logic                  tx_last_o,
  input wire logic                  sample_avail_o,
  input wire logic                  pkt_done_o,
  input wire logic [TSP_SEQ_W-1:0]  seq_count_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] idx_ff;
  logic [3:0] nxt_idx;
  // Octet index is rebuilt from the handshake, not taken from the design.
  always_comb begin
    nxt_idx = idx_ff;
    if (!tx_valid_o) nxt_idx = TSP_IDX_RST;
    else if (tx_ready_i) nxt_idx = idx_ff + 4'h1;
  end
  always_ff @(posedge sys_clk_i) begin
    idx_ff <= rst_i ? TSP_IDX_RST : nxt_idx;
  end
  sequence start_s;
    !tx_valid_o && !pkt_done_o && send_req_i && sample_avail_o;
  endsequence
  sequence first_s;
    tx_valid_o && tx_first_o && tx_data_o == 8'h00;
  endsequence
  sequence end_s;
    tx_valid_o && tx_ready_i && tx_last_o;
  endsequence
  start_first_a: assert property (start_s |=> first_s)
    else $error("first octet missing after start");
  seg_seq_a: assert property (tx_valid_o && idx_ff == 4'h2 |->
    tx_data_o == {2'b11, seq_count_o[13:8]}) else $error("bad seg octet");
  length_a: assert property (tx_valid_o && idx_ff == 4'h5 |->
    tx_data_o == 8'h07) else $error("bad length octet");
  pfield_a: assert property (tx_valid_o && idx_ff == 4'h7 |->
    tx_data_o == 8'h2E) else $error("bad time format octet");
  last_pos_a: assert property (tx_valid_o |->
    tx_last_o == (idx_ff == 4'hD)) else $error("last flag misplaced");
  end_done_a: assert property (end_s |=> !tx_valid_o && pkt_done_o &&
    seq_count_o == $past(seq_count_o) + 14'h0001) else $error("bad end");
  seq_jump_a: assert property ($changed(seq_count_o) |-> pkt_done_o)
    else $error("sequence count moved without a packet");
  hold_a: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("octet dropped");
  hit_avail_a: assert property (marker_start_i && marker_vc_i == 3'h0 &&
    marker_vcfc_i == 8'h00 |=> sample_avail_o) else $error("hit lost");
endmodule : tsp_pkt_checker
bind tsp_packet_builder tsp_pkt_checker tsp_pkt_checker_inst (.sys_clk_i,
  .rst_i, .marker_start_i, .marker_vc_i, .marker_vcfc_i, .send_req_i,
  .tx_data_o, .tx_valid_o, .tx_ready_i, .tx_first_o, .tx_last_o,
  .sample_avail_o, .pkt_done_o, .seq_count_o);
`default_nettype wire

// File: tsp_far_model.sv
// Far-side model: elapsed time counter and a stalling octet sink.
`timescale 1ns/1ps
`default_nettype none
module tsp_far_model
  import tsp_pkg::*;
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    stall_i,
  output logic      [TSP_COARSE_W-1:0] coarse_o,
  output logic      [TSP_FINE_W-1:0]   fine_o,
  output logic                         ready_o
);
  logic [1:0] ph_ff;
  // Subseconds start near wrap so a seconds carry shows up early.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      {coarse_o, fine_o} <= 48'h1234_5678_FFF0;
      ph_ff <= 2'h0;
    end else begin
      {coarse_o, fine_o} <= {coarse_o, fine_o} + 48'h0000_0000_0001;
      ph_ff <= ph_ff + 2'h1;
    end
  end
  // A stalling sink accepts one cycle in four.
  assign ready_o = !stall_i || (ph_ff == 2'h3);
endmodule : tsp_far_model
`default_nettype wire

// File: tsp_packet_builder_tb.sv
// Self-checking testbench of the time packet builder.
`timescale 1ns/1ps
`default_nettype none
module tsp_packet_builder_tb;
  import tsp_pkg::*;
  logic clk, rst, synced, mark, send, clr, stall, ready, valid, last, done;
  logic avail, refused, lost, busy, first;
  logic [TSP_VC_W-1:0] vc;
  logic [TSP_VCFC_W-1:0] fc;
  logic [TSP_RATE_W-1:0] rate;
  logic [7:0] data;
  logic [TSP_SEQ_W-1:0] seq;
  logic [TSP_CNT_W-1:0] pcnt;
  logic [31:0] coarse;
  logic [15:0] fine;
  logic [47:0] t_exp;
  int err_count = 0;
  int checks_done = 0;
  tsp_far_model tsp_far_model_inst (.sys_clk_i(clk), .rst_i(rst),
    .stall_i(stall), .coarse_o(coarse), .fine_o(fine), .ready_o(ready));
  tsp_packet_builder tsp_packet_builder_inst (.sys_clk_i(clk), .rst_i(rst),
    .coarse_time_i(coarse), .fine_time_i(fine), .time_synced_i(synced),
    .marker_start_i(mark), .marker_vc_i(vc), .marker_vcfc_i(fc),
    .send_req_i(send), .rate_code_i(rate), .clr_status_i(clr),
    .tx_data_o(data), .tx_valid_o(valid), .tx_ready_i(ready),
    .tx_first_o(first), .tx_last_o(last), .busy_o(busy),
    .sample_avail_o(avail),
    .req_refused_o(refused), .sample_lost_o(lost), .pkt_done_o(done),
    .seq_count_o(seq), .pkt_count_o(pcnt));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [47:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // Time seen by the design is what the counter shows before the edge.
  task automatic hit(input logic [2:0] v, input logic [7:0] f, input logic s);
    @(posedge clk) #2;
    mark = 1'b1; vc = v; fc = f; synced = s;
    @(negedge clk) t_exp = {coarse, fine};
    t_exp[47] = t_exp[47] | ~s;
    @(posedge clk) #2 mark = 1'b0;
  endtask : hit
  task automatic send_pkt(input logic [3:0] r, input logic [13:0] sq);
    logic [111:0] p;
    int n;
    p = {3'b000, 2'b00, 11'h000, 2'b11, sq, 16'h0007, 4'h0, r, 8'h2E, t_exp};
    n = 0;
    @(posedge clk) #2;
    send = 1'b1; rate = r;
    @(posedge clk) #2;
    send = 1'b0; rate = ~r;
    for (int k = 0; k < 300 && n < 14; k++) begin
      @(negedge clk);
      if (valid === 1'b1 && ready === 1'b1) begin
        chk("octet", {40'h0, data}, {40'h0, p[111-8*n -: 8]});
        chk("first", {47'h0, first}, {47'h0, n == 0});
        chk("busy", {47'h0, busy}, 48'h1);
        if (n == 13) chk("last", {47'h0, last}, 48'h1);
        n++;
      end
    end
    chk("octets", 48'(n), 48'd14);
    @(negedge clk) chk("done", {47'h0, done}, 48'h1);
    chk("seq", {34'h0, seq}, {34'h0, sq + 14'h0001});
    chk("idle", {47'h0, busy}, 48'h0);
  endtask : send_pkt
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    rst = 1'b1; synced = 1'b1; mark = 1'b0; vc = 3'h0; fc = 8'h00;
    send = 1'b0; rate = 4'h0; clr = 1'b0; stall = 1'b0;
    repeat (10) @(posedge clk);
    #2 rst = 1'b0;
    @(negedge clk) chk("seq_rst", {34'h0, seq}, 48'h0);
    @(posedge clk) #2 send = 1'b1;
    @(posedge clk) #2 send = 1'b0;
    chk("refused", {47'h0, refused}, 48'h1);
    chk("no_start", {47'h0, valid}, 48'h0);
    clr = 1'b1;
    @(posedge clk) #2 clr = 1'b0;
    chk("cleared", {47'h0, refused}, 48'h0);
    hit(3'h1, 8'h00, 1'b1);
    chk("vc_miss", {47'h0, avail}, 48'h0);
    hit(3'h0, 8'h05, 1'b1);
    chk("fc_miss", {47'h0, avail}, 48'h0);
    hit(3'h0, 8'h00, 1'b1);
    chk("hit", {47'h0, avail}, 48'h1);
    // A second reference marker before any packet overwrites the sample.
    hit(3'h0, 8'h00, 1'b1);
    chk("lost", {47'h0, lost}, 48'h1);
    send_pkt(4'hA, 14'h0000);
    @(posedge clk) #2 stall = 1'b1;
    hit(3'h0, 8'h00, 1'b0);
    send_pkt(4'h5, 14'h0001);
    @(posedge clk) #2 stall = 1'b0;
    hit(3'h0, 8'h00, 1'b1);
    send_pkt(4'hF, 14'h0002);
    chk("pkt_count", {32'h0, pcnt}, 48'h3);
    // Reset is held two edges, then the count's return to zero is checked.
    @(posedge clk) #2 rst = 1'b1;
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    chk("seq_rerst", {34'h0, seq}, 48'h0);
    chk("cnt_rerst", {32'h0, pcnt}, 48'h0);
    chk("avail_rerst", {47'h0, avail}, 48'h0);
    hit(3'h0, 8'h00, 1'b1);
    send_pkt(4'h3, 14'h0000);
    print_verdict();
  end
endmodule : tsp_packet_builder_tb
`default_nettype wire
